// [hw/sfpi_pkg.sv]
// constants and types shared by the serial flash pin interface
package sfpi_pkg;

    // ------------------------------------------------------------------
    // line modes
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        SFPI_LANES_SINGLE,
        SFPI_LANES_DUAL,
        SFPI_LANES_QUAD
    } sfpi_lanes_t;

    // ------------------------------------------------------------------
    // counts and reset values
    // ------------------------------------------------------------------
    localparam int          SFPI_SYNC_STAGES   = 2;
    localparam logic [3:0]  SFPI_BYTE_BITS     = 4'h8;
    localparam logic [3:0]  SFPI_STEP_SINGLE   = 4'h1;
    localparam logic [3:0]  SFPI_STEP_DUAL     = 4'h2;
    localparam logic [3:0]  SFPI_STEP_QUAD     = 4'h4;
    localparam logic        SFPI_WPE_RESET     = 1'b0;
    localparam logic [3:0]  SFPI_GUARD_ALL     = 4'hF;
    localparam logic [7:0]  SFPI_BYTE_RESET    = 8'h00;
    localparam logic [3:0]  SFPI_CNT_RESET     = 4'h0;

endpackage

// [hw/sfpi_sync.sv]
// two-stage synchroniser for the pin inputs
`timescale 1ns/1ns
module sfpi_sync #(
    parameter int WIDTH = 6
) (
    input  wire logic             core_clk,
    input  wire logic             resetn,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1_q;
    logic [WIDTH-1:0] stage2_q;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            stage1_q <= '0;
            stage2_q <= '0;
        end else begin
            stage1_q <= async_in;
            stage2_q <= stage1_q;
        end
    end

    assign sync_out = stage2_q;

endmodule

// [hw/sfpi_core.sv]
// serial flash pin interface: select, sampling and driving edges, line muxing, pause and protect
`timescale 1ns/1ns
module sfpi_core (
    input  wire logic        core_clk,
    input  wire logic        resetn,
    // pins
    input  wire logic        cs_n,
    input  wire logic        sclk,
    input  wire logic        data_line_0_pin,
    output logic             data_line_0_drv,
    output logic             data_line_0_oe,
    input  wire logic        data_line_1_pin,
    output logic             data_line_1_drv,
    output logic             data_line_1_oe,
    input  wire logic        data_line_2_pin,
    output logic             data_line_2_drv,
    output logic             data_line_2_oe,
    input  wire logic        data_line_3_pin,
    output logic             data_line_3_drv,
    output logic             data_line_3_oe,
    // configuration from the command decoder
    input  wire logic        wp_enable,
    input  wire logic [3:0]  block_guard_bits,
    input  wire logic [1:0]  reg_guard_bits,
    input  wire logic [1:0]  rx_lanes,
    input  wire logic [1:0]  tx_lanes,
    input  wire logic        tx_en,
    input  wire logic [7:0]  tx_data,
    // results
    output logic [7:0]       instr_code,
    output logic             instr_valid,
    output logic [7:0]       rx_data,
    output logic             rx_valid,
    output logic             tx_take,
    output logic             frame_active,
    output logic             paused,
    output logic             quad_reject,
    output logic             reg_write_block,
    output logic             array_write_block,
    output logic [3:0]       guard_region
);

    // ------------------------------------------------------------------
    // pin synchronisation and edge detection
    // ------------------------------------------------------------------
    logic [5:0] pin_s;
    logic       cs_n_s;
    logic       sclk_s;
    logic [3:0] din_s;

    sfpi_sync #(
        .WIDTH (6)
    ) u_sync (
        .core_clk (core_clk),
        .resetn   (resetn),
        .async_in ({cs_n, sclk, data_line_3_pin, data_line_2_pin, data_line_1_pin, data_line_0_pin}),
        .sync_out (pin_s)
    );

    assign cs_n_s = pin_s[5];
    assign sclk_s = pin_s[4];
    assign din_s  = pin_s[3:0];

    logic sclk_p_q;
    logic cs_n_p_q;
    logic rise_ev;
    logic fall_ev;
    logic cs_fall_ev;

    // edges found from the sampled clock, so either idle level works
    assign rise_ev    = sclk_s & ~sclk_p_q;
    assign fall_ev    = ~sclk_s & sclk_p_q;
    assign cs_fall_ev = ~cs_n_s & cs_n_p_q;

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic        armed_q,   armed_d;
    logic        wpe_q,     wpe_d;
    logic        paused_q,  paused_d;
    logic        qlock_q,   qlock_d;
    logic        idone_q,   idone_d;
    logic [3:0]  rcnt_q,    rcnt_d;
    logic [7:0]  rsh_q,     rsh_d;
    logic [3:0]  tcnt_q,    tcnt_d;
    logic [7:0]  tsh_q,     tsh_d;
    logic [7:0]  instr_q,   instr_d;
    logic        ival_q,    ival_d;
    logic [7:0]  rxd_q,     rxd_d;
    logic        rval_q,    rval_d;
    logic        take_q,    take_d;
    logic        qrej_q,    qrej_d;
    logic [3:0]  dout_q,    dout_d;
    logic [3:0]  oe_q,      oe_d;
    logic        rwb_q,     rwb_d;
    logic        awb_q,     awb_d;
    logic [3:0]  guard_q,   guard_d;

    logic        active;
    logic        hold_req;
    logic        wp_low;
    sfpi_pkg::sfpi_lanes_t rl;
    sfpi_pkg::sfpi_lanes_t tl;
    logic [3:0]  rstep;
    logic [3:0]  tstep;
    logic [7:0]  nsh;
    logic [3:0]  nsum;
    logic [7:0]  tbyte;

    assign active = armed_q & ~cs_n_s;
    assign rl     = idone_q ? sfpi_pkg::sfpi_lanes_t'(rx_lanes) : sfpi_pkg::SFPI_LANES_SINGLE;
    assign tl     = sfpi_pkg::sfpi_lanes_t'(tx_lanes);

    // ------------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        armed_d  = armed_q;
        wpe_d    = wp_enable;
        paused_d = paused_q;
        qlock_d  = qlock_q;
        idone_d  = idone_q;
        rcnt_d   = rcnt_q;
        rsh_d    = rsh_q;
        tcnt_d   = tcnt_q;
        tsh_d    = tsh_q;
        instr_d  = instr_q;
        ival_d   = 1'b0;
        rxd_d    = rxd_q;
        rval_d   = 1'b0;
        take_d   = 1'b0;
        qrej_d   = 1'b0;
        dout_d   = dout_q;
        oe_d     = 4'h0;
        nsh      = rsh_q;
        nsum     = rcnt_q;
        tbyte    = tsh_q;
        rstep    = sfpi_pkg::SFPI_STEP_SINGLE;
        tstep    = sfpi_pkg::SFPI_STEP_SINGLE;
        hold_req = 1'b0;
        wp_low   = 1'b0;

        unique case (rl)
            sfpi_pkg::SFPI_LANES_DUAL: rstep = sfpi_pkg::SFPI_STEP_DUAL;
            sfpi_pkg::SFPI_LANES_QUAD: rstep = sfpi_pkg::SFPI_STEP_QUAD;
            default:                   rstep = sfpi_pkg::SFPI_STEP_SINGLE;
        endcase
        unique case (tl)
            sfpi_pkg::SFPI_LANES_DUAL: tstep = sfpi_pkg::SFPI_STEP_DUAL;
            sfpi_pkg::SFPI_LANES_QUAD: tstep = sfpi_pkg::SFPI_STEP_QUAD;
            default:                   tstep = sfpi_pkg::SFPI_STEP_SINGLE;
        endcase

        // first select fall after reset arms the interface
        if (cs_fall_ev) begin
            armed_d = 1'b1;
        end

        // quad use locks the pause pin as a data line for the frame
        if (active && !wpe_q && ((idone_q && rl == sfpi_pkg::SFPI_LANES_QUAD)
                || (tx_en && tl == sfpi_pkg::SFPI_LANES_QUAD))) begin
            qlock_d = 1'b1;
        end

        // pause request only outside quad transfers
        hold_req = active && !qlock_q && !din_s[3];
        if (!sclk_s || qlock_q) begin
            paused_d = hold_req;
        end

        // rising edge: capture
        if (active && !paused_q && rise_ev) begin
            if (rl == sfpi_pkg::SFPI_LANES_QUAD && wpe_q) begin
                qrej_d = 1'b1;
            end else begin
                unique case (rl)
                    sfpi_pkg::SFPI_LANES_DUAL: nsh = {rsh_q[5:0], din_s[1:0]};
                    sfpi_pkg::SFPI_LANES_QUAD: nsh = {rsh_q[3:0], din_s};
                    default:                   nsh = {rsh_q[6:0], din_s[0]};
                endcase
                nsum  = 4'(rcnt_q + rstep);
                rsh_d = nsh;
                if (nsum >= sfpi_pkg::SFPI_BYTE_BITS) begin
                    rcnt_d = sfpi_pkg::SFPI_CNT_RESET;
                    if (!idone_q) begin
                        instr_d = nsh;
                        ival_d  = 1'b1;
                        idone_d = 1'b1;
                    end else begin
                        rxd_d  = nsh;
                        rval_d = 1'b1;
                    end
                end else begin
                    rcnt_d = nsum;
                end
            end
        end

        // falling edge: drive
        if (active && !paused_q && tx_en && fall_ev) begin
            if (tl == sfpi_pkg::SFPI_LANES_QUAD && wpe_q) begin
                qrej_d = 1'b1;
            end else begin
                if (tcnt_q == sfpi_pkg::SFPI_CNT_RESET) begin
                    tbyte  = tx_data;
                    take_d = 1'b1;
                    tcnt_d = 4'(sfpi_pkg::SFPI_BYTE_BITS - tstep);
                end else begin
                    tcnt_d = 4'(tcnt_q - tstep);
                end
                unique case (tl)
                    sfpi_pkg::SFPI_LANES_DUAL: begin
                        dout_d = {dout_q[3:2], tbyte[7:6]};
                        tsh_d  = {tbyte[5:0], 2'b00};
                    end
                    sfpi_pkg::SFPI_LANES_QUAD: begin
                        dout_d = tbyte[7:4];
                        tsh_d  = {tbyte[3:0], 4'h0};
                    end
                    default: begin
                        dout_d = {dout_q[3:2], tbyte[7], dout_q[0]};
                        tsh_d  = {tbyte[6:0], 1'b0};
                    end
                endcase
            end
        end

        // output enables follow lane mode; paused or deselected floats all
        if (active && !paused_q && tx_en) begin
            unique case (tl)
                sfpi_pkg::SFPI_LANES_DUAL: oe_d = 4'h3;
                sfpi_pkg::SFPI_LANES_QUAD: oe_d = wpe_q ? 4'h0 : 4'hF;
                default:                   oe_d = 4'h2;
            endcase
        end

        // protect pin is data while quad-locked
        wp_low = !din_s[2] && !qlock_q;
        rwb_d  = wp_low && (wpe_q || reg_guard_bits != 2'b00);
        awb_d  = wp_low && wpe_q;
        guard_d = awb_d ? sfpi_pkg::SFPI_GUARD_ALL : block_guard_bits;

        // deselect ends the frame
        if (cs_n_s) begin
            oe_d     = 4'h0;
            paused_d = 1'b0;
            qlock_d  = 1'b0;
            idone_d  = 1'b0;
            rcnt_d   = sfpi_pkg::SFPI_CNT_RESET;
            tcnt_d   = sfpi_pkg::SFPI_CNT_RESET;
        end
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            sclk_p_q <= 1'b0;
            cs_n_p_q <= 1'b0;
            armed_q  <= 1'b0;
            wpe_q    <= sfpi_pkg::SFPI_WPE_RESET;
            paused_q <= 1'b0;
            qlock_q  <= 1'b0;
            idone_q  <= 1'b0;
            rcnt_q   <= sfpi_pkg::SFPI_CNT_RESET;
            rsh_q    <= sfpi_pkg::SFPI_BYTE_RESET;
            tcnt_q   <= sfpi_pkg::SFPI_CNT_RESET;
            tsh_q    <= sfpi_pkg::SFPI_BYTE_RESET;
            instr_q  <= sfpi_pkg::SFPI_BYTE_RESET;
            ival_q   <= 1'b0;
            rxd_q    <= sfpi_pkg::SFPI_BYTE_RESET;
            rval_q   <= 1'b0;
            take_q   <= 1'b0;
            qrej_q   <= 1'b0;
            dout_q   <= 4'h0;
            oe_q     <= 4'h0;
            rwb_q    <= 1'b0;
            awb_q    <= 1'b0;
            guard_q  <= 4'h0;
        end else begin
            sclk_p_q <= sclk_s;
            cs_n_p_q <= cs_n_s;
            armed_q  <= armed_d;
            wpe_q    <= wpe_d;
            paused_q <= paused_d;
            qlock_q  <= qlock_d;
            idone_q  <= idone_d;
            rcnt_q   <= rcnt_d;
            rsh_q    <= rsh_d;
            tcnt_q   <= tcnt_d;
            tsh_q    <= tsh_d;
            instr_q  <= instr_d;
            ival_q   <= ival_d;
            rxd_q    <= rxd_d;
            rval_q   <= rval_d;
            take_q   <= take_d;
            qrej_q   <= qrej_d;
            dout_q   <= dout_d;
            oe_q     <= oe_d;
            rwb_q    <= rwb_d;
            awb_q    <= awb_d;
            guard_q  <= guard_d;
        end
    end

    assign data_line_0_drv   = dout_q[0];
    assign data_line_1_drv   = dout_q[1];
    assign data_line_2_drv   = dout_q[2];
    assign data_line_3_drv   = dout_q[3];
    assign data_line_0_oe    = oe_q[0];
    assign data_line_1_oe    = oe_q[1];
    assign data_line_2_oe    = oe_q[2];
    assign data_line_3_oe    = oe_q[3];
    assign instr_code        = instr_q;
    assign instr_valid       = ival_q;
    assign rx_data           = rxd_q;
    assign rx_valid          = rval_q;
    assign tx_take           = take_q;
    assign frame_active      = idone_q;
    assign paused            = paused_q;
    assign quad_reject       = qrej_q;
    assign reg_write_block   = rwb_q;
    assign array_write_block = awb_q;
    assign guard_region      = guard_q;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);

    sequence seq_hold_clk_low;
        hold_req && !sclk_s;
    endsequence

    sequence seq_pause_taken;
        ##1 paused_q;
    endsequence

    chk_desel_float:   assert property (cs_n_s |=> oe_q == 4'h0)
        else $error("data line driven while deselected");
    chk_arm_first:     assert property (!armed_q |=> !ival_q)
        else $error("instruction taken before first select");
    chk_instr_on_rise: assert property ($rose(ival_q) |-> $past(rise_ev) && $past(!idone_q))
        else $error("instruction byte not closed by a rising edge");
    chk_drive_on_fall: assert property ($changed(dout_q) |-> $past(fall_ev) && $past(tx_en))
        else $error("output data changed away from a falling edge");
    chk_quad_oe:       assert property (active && tx_en && !paused_q && !wpe_q && !cs_n_s
                                        && tl == sfpi_pkg::SFPI_LANES_QUAD |=> oe_q == 4'hF)
        else $error("quad drive without all four enables");
    chk_dual_oe:       assert property (active && tx_en && !paused_q && !cs_n_s
                                        && tl == sfpi_pkg::SFPI_LANES_DUAL |=> oe_q == 4'h3)
        else $error("dual drive enables wrong");
    chk_hw_protect:    assert property (wpe_q && !din_s[2] && !qlock_q |=> awb_q && rwb_q
                                        && guard_q == sfpi_pkg::SFPI_GUARD_ALL)
        else $error("protect pin low did not block writes");
    chk_quad_reject:   assert property (wpe_q && active && !paused_q && rise_ev && idone_q
                                        && rl == sfpi_pkg::SFPI_LANES_QUAD |=> qrej_q && !rval_q)
        else $error("quad transfer not rejected");
    chk_pause_float:   assert property (paused_q |=> oe_q == 4'h0)
        else $error("output driven during pause");
    chk_pause_start:   assert property (seq_hold_clk_low |-> seq_pause_taken)
        else $error("pause did not start with clock low");
    chk_quad_nopause:  assert property (qlock_q |=> !paused_q)
        else $error("pause taken during quad transfer");

endmodule

// [sim/sfpi_host_model.sv]
// spi host model: drives select, serial clock and the four data lines
`timescale 1ns/1ns
module sfpi_host_model (
    input  wire logic       core_clk,
    input  wire logic [3:0] pin,
    output logic            cs_n,
    output logic            sclk,
    output logic [3:0]      host_val,
    output logic [3:0]      host_oe
);
    logic [3:0] held;

    initial begin
        cs_n     = 1'b0;
        sclk     = 1'b0;
        host_val = 4'hF;
        host_oe  = 4'hD;
        held     = 4'hF;
    end

    task automatic wait_n(input int n);
        repeat (n) @(negedge core_clk);
    endtask

    // clock parked at the mode idle level before select falls
    task automatic begin_frame(input logic m3);
        @(negedge core_clk);
        sclk <= m3;
        wait_n(2);
        cs_n <= 1'b0;
        wait_n(4);
    endtask

    task automatic end_frame(input logic m3);
        @(negedge core_clk);
        sclk <= m3;
        wait_n(4);
        cs_n    <= 1'b1;
        host_oe <= 4'hC;
        wait_n(8);
    endtask

    task automatic hold_line(input int idx, input logic lvl);
        @(negedge core_clk);
        held[idx]     = lvl;
        host_val[idx] <= lvl;
    endtask

    task automatic set_clk(input logic lvl);
        @(negedge core_clk);
        sclk <= lvl;
        wait_n(8);
    endtask

    // data changes with the falling clock, read data sampled late in the high phase
    task automatic xfer(input logic [7:0] tx, input int lanes, input logic [3:0] oe, output logic [7:0] rx);
        logic [7:0] s;
        logic [3:0] v;
        int         k;
        s  = tx;
        rx = 8'h00;
        for (k = 0; k < 8 / lanes; k++) begin
            @(negedge core_clk);
            host_oe <= oe;
            sclk    <= 1'b0;
            case (lanes)
                1: v = {held[3:2], 1'b0, s[7]};
                2: v = {held[3:2], s[7:6]};
                default: v = s[7:4];
            endcase
            host_val <= v;
            s = s << lanes;
            wait_n(4);
            sclk <= 1'b1;
            wait_n(4);
            if (lanes == 1) rx = {rx[6:0], pin[1]};
            else if (lanes == 2) rx = {rx[5:0], pin[1:0]};
            else rx = {rx[3:0], pin};
        end
        wait_n(8);
    endtask
endmodule

// [sim/tb_serial_flash_pin_interface.sv]
// testbench for the serial flash pin interface core
`timescale 1ns/1ns
module tb_serial_flash_pin_interface;
    logic       core_clk;
    logic       resetn;
    logic       cs_n;
    logic       sclk;
    logic [3:0] host_val;
    logic [3:0] host_oe;
    logic [3:0] drv;
    logic [3:0] oes;
    logic [3:0] pin;
    logic       flt;
    logic       wp_enable;
    logic [3:0] block_guard_bits;
    logic [1:0] reg_guard_bits;
    logic [1:0] rx_lanes;
    logic [1:0] tx_lanes;
    logic       tx_en;
    logic [7:0] tx_data;
    logic [7:0] instr_code;
    logic       instr_valid;
    logic [7:0] rx_data;
    logic       rx_valid;
    logic       tx_take;
    logic       frame_active;
    logic       paused;
    logic       quad_reject;
    logic       reg_write_block;
    logic       array_write_block;
    logic [3:0] guard_region;
    logic [7:0] last_instr;
    logic [7:0] last_rx;
    logic [7:0] r;
    logic       paused_seen;
    int         n_instr;
    int         n_rx;
    int         n_rej;
    int         n_take;
    int         n0;
    int         mismatches;
    int         samples_checked;

    // undriven lines wander instead of holding the last value
    always_comb for (int i = 0; i < 4; i++) pin[i] = oes[i] ? drv[i] : (host_oe[i] ? host_val[i] : flt);

    sfpi_host_model u_sfpi_host_model (
        .core_clk (core_clk),
        .pin      (pin),
        .cs_n     (cs_n),
        .sclk     (sclk),
        .host_val (host_val),
        .host_oe  (host_oe)
    );

    sfpi_core u_sfpi_core (
        .core_clk          (core_clk),
        .resetn            (resetn),
        .cs_n              (cs_n),
        .sclk              (sclk),
        .data_line_0_pin   (pin[0]),
        .data_line_0_drv   (drv[0]),
        .data_line_0_oe    (oes[0]),
        .data_line_1_pin   (pin[1]),
        .data_line_1_drv   (drv[1]),
        .data_line_1_oe    (oes[1]),
        .data_line_2_pin   (pin[2]),
        .data_line_2_drv   (drv[2]),
        .data_line_2_oe    (oes[2]),
        .data_line_3_pin   (pin[3]),
        .data_line_3_drv   (drv[3]),
        .data_line_3_oe    (oes[3]),
        .wp_enable         (wp_enable),
        .block_guard_bits  (block_guard_bits),
        .reg_guard_bits    (reg_guard_bits),
        .rx_lanes          (rx_lanes),
        .tx_lanes          (tx_lanes),
        .tx_en             (tx_en),
        .tx_data           (tx_data),
        .instr_code        (instr_code),
        .instr_valid       (instr_valid),
        .rx_data           (rx_data),
        .rx_valid          (rx_valid),
        .tx_take           (tx_take),
        .frame_active      (frame_active),
        .paused            (paused),
        .quad_reject       (quad_reject),
        .reg_write_block   (reg_write_block),
        .array_write_block (array_write_block),
        .guard_region      (guard_region)
    );

    initial begin
        core_clk = 1'b0;
        flt      = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    always @(negedge core_clk) flt <= ~flt;

    // pulse monitors
    always @(posedge core_clk) begin
        if (instr_valid === 1'b1) begin
            n_instr++;
            last_instr = instr_code;
        end
        if (rx_valid === 1'b1) begin
            n_rx++;
            last_rx = rx_data;
        end
        if (quad_reject === 1'b1) n_rej++;
        if (tx_take === 1'b1) n_take++;
        if (paused === 1'b1) paused_seen = 1'b1;
    end

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic results();
        if (mismatches == 0 && samples_checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    task automatic set_lanes(input logic [1:0] ln, input logic en, input logic [7:0] d);
        @(negedge core_clk);
        rx_lanes = ln;
        tx_lanes = ln;
        tx_en    = en;
        tx_data  = d;
    endtask

    task automatic set_cfg(input logic we, input logic [1:0] rg, input logic [3:0] bg);
        @(negedge core_clk);
        wp_enable        = we;
        reg_guard_bits   = rg;
        block_guard_bits = bg;
        u_sfpi_host_model.wait_n(6);
    endtask

    // single-lane instruction, then one written byte and one read byte in the given lane mode
    task automatic frame_rw(input logic m3, input logic [1:0] ln, input int n, input logic [3:0] woe,
                            input logic [3:0] roe, input logic [7:0] ins, input logic [7:0] wd, input logic [7:0] rd);
        set_lanes(ln, 1'b0, rd);
        u_sfpi_host_model.begin_frame(m3);
        u_sfpi_host_model.xfer(ins, 1, 4'hD, r);
        check("instr_code", last_instr, ins);
        check("frame active", {7'h0, frame_active}, 8'h01);
        u_sfpi_host_model.xfer(wd, n, woe, r);
        check("rx_data", last_rx, wd);
        set_lanes(ln, 1'b1, rd);
        n0 = n_take;
        u_sfpi_host_model.xfer(8'h00, n, roe, r);
        check("read data", r, rd);
        check("line enables", {4'h0, oes}, {4'h0, ~roe});
        check("tx take count", 8'(n_take - n0), 8'h01);
        set_lanes(ln, 1'b0, rd);
        u_sfpi_host_model.end_frame(m3);
        check("idle enables", {4'h0, oes}, 8'h00);
        check("frame closed", {7'h0, frame_active}, 8'h00);
    endtask

    initial begin
        resetn = 1'b0;
        fork
            set_lanes(sfpi_pkg::SFPI_LANES_SINGLE, 1'b0, 8'h00);
            set_cfg(1'b0, 2'h0, 4'h0);
        join_none
        {n_instr, n_rx, n_rej, n_take, mismatches, samples_checked} = '0;
        paused_seen = 1'b0;
        repeat (5) @(posedge core_clk);
        @(negedge core_clk);
        resetn = 1'b1;
        // select low since power-up: no instruction until it falls
        u_sfpi_host_model.xfer(8'hA5, 1, 4'hD, r);
        check("instr count", 8'(n_instr), 8'h00);
        u_sfpi_host_model.end_frame(1'b0);
        check("idle enables", {4'h0, oes}, 8'h00);
        frame_rw(1'b0, sfpi_pkg::SFPI_LANES_SINGLE, 1, 4'hD, 4'hD, 8'hA5, 8'h3C, 8'h96);
        frame_rw(1'b1, sfpi_pkg::SFPI_LANES_SINGLE, 1, 4'hD, 4'hD, 8'h5A, 8'hC3, 8'h69);
        frame_rw(1'b1, sfpi_pkg::SFPI_LANES_DUAL, 2, 4'hF, 4'hC, 8'hBB, 8'hC6, 8'h4E);
        paused_seen = 1'b0;
        frame_rw(1'b0, sfpi_pkg::SFPI_LANES_QUAD, 4, 4'hF, 4'h0, 8'hEB, 8'h7D, 8'hE1);
        check("no pause in quad", {7'h0, paused_seen}, 8'h00);
        // quad capture refused with protect enable set
        set_cfg(1'b1, 2'h0, 4'h0);
        n0 = n_rx;
        u_sfpi_host_model.begin_frame(1'b0);
        u_sfpi_host_model.xfer(8'h6B, 1, 4'hD, r);
        u_sfpi_host_model.xfer(8'hDE, 4, 4'hF, r);
        check("quad reject count", 8'(n_rej), 8'h02);
        check("quad rx count", 8'(n_rx - n0), 8'h00);
        u_sfpi_host_model.end_frame(1'b0);
        set_cfg(1'b0, 2'h0, 4'h0);
        set_lanes(sfpi_pkg::SFPI_LANES_SINGLE, 1'b0, 8'hA5);
        // pause in mode 3: starts only after the next falling clock edge
        u_sfpi_host_model.begin_frame(1'b1);
        u_sfpi_host_model.xfer(8'h02, 1, 4'hD, r);
        set_lanes(sfpi_pkg::SFPI_LANES_SINGLE, 1'b1, 8'hA5);
        u_sfpi_host_model.hold_line(3, 1'b0);
        u_sfpi_host_model.wait_n(8);
        check("paused clock high", {7'h0, paused}, 8'h00);
        u_sfpi_host_model.set_clk(1'b0);
        check("paused clock low", {7'h0, paused}, 8'h01);
        check("out enable paused", {7'h0, oes[1]}, 8'h00);
        n0 = n_rx;
        u_sfpi_host_model.xfer(8'hFF, 1, 4'hD, r);
        check("rx while paused", 8'(n_rx - n0), 8'h00);
        u_sfpi_host_model.hold_line(3, 1'b1);
        u_sfpi_host_model.set_clk(1'b0);
        check("pause released", {7'h0, paused}, 8'h00);
        u_sfpi_host_model.xfer(8'h81, 1, 4'hD, r);
        check("rx after pause", last_rx, 8'h81);
        set_lanes(sfpi_pkg::SFPI_LANES_SINGLE, 1'b0, 8'hA5);
        u_sfpi_host_model.end_frame(1'b1);
        // protect pin in both protection modes
        u_sfpi_host_model.hold_line(2, 1'b0);
        set_cfg(1'b0, 2'h1, 4'h3);
        check("reg block soft", {7'h0, reg_write_block}, 8'h01);
        check("array block soft", {7'h0, array_write_block}, 8'h00);
        set_cfg(1'b0, 2'h0, 4'h3);
        check("reg block open", {7'h0, reg_write_block}, 8'h00);
        set_cfg(1'b1, 2'h0, 4'h3);
        check("reg block hard", {7'h0, reg_write_block}, 8'h01);
        check("array block hard", {7'h0, array_write_block}, 8'h01);
        check("guard region hard", {4'h0, guard_region}, 8'h0F);
        u_sfpi_host_model.hold_line(2, 1'b1);
        set_cfg(1'b0, 2'h0, 4'h3);
        check("array block released", {7'h0, array_write_block}, 8'h00);
        check("guard region", {4'h0, guard_region}, 8'h03);
        results();
    end

    initial begin
        #400000;
        mismatches++;
        results();
    end
endmodule
